// ---- logic/mon_pkg.sv ----
// Purpose: shared constants and types of the variable monitor outputs
// Assumes: plain register port, byte offsets as printed, 16-bit variables
// Notes:   one per-unit equals 2**PU_FRAC counts of a signed variable
package mon_pkg;

  // register port
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam logic [11:0] CUR_GAIN_OFS  = 12'h0f0;
  localparam logic [11:0] SPD_GAIN_OFS  = 12'h0f2;
  localparam logic [11:0] OUT1_CTRL_OFS = 12'h0f4;
  localparam logic [11:0] OUT2_CTRL_OFS = 12'h0f6;
  localparam logic [11:0] OUT1_STAT_OFS = 12'h0f8;
  localparam logic [11:0] OUT2_STAT_OFS = 12'h0fa;

  // gain readback layout
  localparam int GAIN_W      = 10;
  localparam int GAIN_HI_LSB = 16;

  // control fields, channel one
  localparam int ADDR1_W    = 12;
  localparam int POL1_BIT   = 12;
  localparam int SCALE1_LSB = 13;
  localparam int MULT1_LSB  = 17;
  // control fields, channel two
  localparam int ADDR2_W    = 14;
  localparam int POL2_BIT   = 14;
  localparam int SCALE2_LSB = 15;
  localparam int MULT2_LSB  = 19;
  localparam int FIELD_W    = 4;

  localparam logic [31:0] CTRL1_WMASK = 32'h001fffff;
  localparam logic [31:0] CTRL2_WMASK = 32'h007fffff;
  localparam logic [31:0] CTRL1_RST   = 32'h00110000;
  localparam logic [31:0] CTRL2_RST   = 32'h00440000;

  // variable and scaling
  localparam int         VAR_W       = 16;
  localparam int         VAR_ADDR_W  = 14;
  localparam int         STAT_LSB    = 16;
  localparam int         PU_FRAC     = 15;
  localparam int         SCALE_SHIFT = 3;
  localparam logic [4:0] ENUM_MAX    = 5'h1f;
  localparam int         NUM_CH      = 2;

  typedef enum logic [1:0] {
    FETCH_ONE = 2'h0,
    TAKE_ONE  = 2'h1,
    FETCH_TWO = 2'h3,
    TAKE_TWO  = 2'h2
  } fetch_state_t;

endpackage

// ---- logic/mon_chan_if.sv ----
// Purpose: one monitor channel, fetched variable plus its scaling setup
// Assumes: single clock domain
// Notes:   src is the register/fetch side, sink the scaler
`timescale 1ns/100ps
`default_nettype none
interface mon_chan_if;
  logic [mon_pkg::VAR_W-1:0]   var_value;
  logic                        var_fresh;
  logic [mon_pkg::FIELD_W-1:0] scale;
  logic [mon_pkg::FIELD_W-1:0] mult;
  logic                        unipolar;
  modport src  (output var_value, var_fresh, scale, mult, unipolar);
  modport sink (input  var_value, var_fresh, scale, mult, unipolar);
endinterface
`default_nettype wire

// ---- logic/mon_reset_sync.sv ----
// Purpose: release of the asynchronous reset through two flip-flops
// Assumes: resetn_i may be asynchronous to clk_i
// Notes:   assertion is immediate, release takes two edges
`timescale 1ns/100ps
`default_nettype none
module mon_reset_sync (
  // clock and raw reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // synchronised reset
  output logic      rst_no
);
  typedef struct packed {
    logic meta;
    logic sync;
  } rst_state_t;

  rst_state_t s_q;
  rst_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = 1'b1;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rst_no = s_q.sync;
endmodule
`default_nettype wire

// ---- logic/mon_scaler.sv ----
// Purpose: scale one monitored variable into an output code
// Assumes: variable is signed with PU_FRAC fraction bits
// Notes:   code updates one edge after each fresh fetch
`timescale 1ns/100ps
`default_nettype none
module mon_scaler #(
  parameter int CODE_W = 12
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_ni,
  // channel
  mon_chan_if.sink         ch,
  // output code
  output logic [CODE_W-1:0] code_o
);
  localparam logic signed [31:0] CODE_MAX = 32'sd2 ** CODE_W - 32'sd1;
  localparam logic signed [31:0] PU_ONE   = 32'sd2 ** mon_pkg::PU_FRAC;

  typedef struct packed {
    logic [CODE_W-1:0] code;
  } scl_state_t;

  scl_state_t         s_q;
  scl_state_t         s_d;
  logic signed [31:0] wide;
  logic signed [31:0] scaled;
  logic signed [31:0] level;
  logic [4:0]         enum_v;

  always_comb begin
    s_d    = s_q;
    wide   = 32'(signed'(ch.var_value));
    enum_v = '0;
    if (ch.scale != '0) begin
      scaled = (wide * $signed({28'h0, ch.scale})) >>> mon_pkg::SCALE_SHIFT;
    end else begin
      // enum values are clipped to 0..31, never wrapped
      if (wide < 0) begin
        enum_v = '0;
      end else if (wide > 32'(mon_pkg::ENUM_MAX)) begin
        enum_v = mon_pkg::ENUM_MAX;
      end else begin
        enum_v = wide[4:0];
      end
      scaled = $signed({27'h0, enum_v}) <<< ch.mult;
    end
    if (ch.unipolar) begin
      level = scaled >>> (mon_pkg::PU_FRAC - CODE_W);
    end else begin
      level = (scaled + PU_ONE) >>> (mon_pkg::PU_FRAC + 1 - CODE_W);
    end
    if (ch.var_fresh) begin
      if (level < 0) begin
        s_d.code = '0;
      end else if (level > CODE_MAX) begin
        s_d.code = CODE_MAX[CODE_W-1:0];
      end else begin
        s_d.code = level[CODE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign code_o = s_q.code;
endmodule
`default_nettype wire

// ---- logic/dac_variable_monitor.sv ----
// Purpose: two analogue monitor channels plus loop gain readback
// Assumes: variable store answers one cycle after var_rd_o
// Notes:   channels are fetched in turn, one every two cycles
//
// How it works
// - current loop gains readable, Ki high, Kp low
// - speed loop gains readable, Ki high, Kp low
// - channel one fetches variable at 12-bit address
// - channel two fetches variable at 14-bit address
// - channel one nonzero scale multiplies by N/8
// - channel one zero scale uses power-of-two multiplier
// - zero scale treats variable as enum, max 31
// - channel one unipolar maps 0..1 pu to 0..3V
// - bipolar maps -1..1 pu, zero at midscale
// - channel two nonzero scale multiplies by N/8
// - channel two zero scale uses power-of-two multiplier
// - channel two has own polarity bit
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dac_variable_monitor #(
  parameter int CODE_W = 12
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  // register port
  input  wire logic [mon_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [mon_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic [mon_pkg::DATA_W-1:0]      reg_rdata_o,
  // gains in use by the loop controllers
  input  wire logic [mon_pkg::GAIN_W-1:0] cur_integral_gain_i,
  input  wire logic [mon_pkg::GAIN_W-1:0] cur_proportional_gain_i,
  input  wire logic [mon_pkg::GAIN_W-1:0] spd_integral_gain_i,
  input  wire logic [mon_pkg::GAIN_W-1:0] spd_proportional_gain_i,
  // algorithm variable fetch
  output logic                            var_rd_o,
  output logic [mon_pkg::VAR_ADDR_W-1:0]  var_addr_o,
  input  wire logic [mon_pkg::VAR_W-1:0]  var_rdata_i,
  // monitor codes to the converters
  output logic [CODE_W-1:0]               monitor_out_one_o,
  output logic [CODE_W-1:0]               monitor_out_two_o
);

  typedef struct packed {
    logic [mon_pkg::DATA_W-1:0]                  ctrl1;
    logic [mon_pkg::DATA_W-1:0]                  ctrl2;
    logic [mon_pkg::DATA_W-1:0]                  rdata;
    mon_pkg::fetch_state_t                       fstate;
    logic [mon_pkg::VAR_ADDR_W-1:0]              vaddr;
    logic [mon_pkg::NUM_CH-1:0][mon_pkg::VAR_W-1:0] raw;
    logic [mon_pkg::NUM_CH-1:0]                  fresh;
  } top_state_t;

  logic                       rst_n;
  top_state_t                 s_q;
  top_state_t                 s_d;
  logic [mon_pkg::NUM_CH-1:0][CODE_W-1:0] code;
  logic [mon_pkg::ADDR1_W-1:0] addr_one;
  logic [mon_pkg::ADDR2_W-1:0] addr_two;

  mon_chan_if ch [mon_pkg::NUM_CH] ();

  mon_reset_sync u_rst (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .rst_no   (rst_n)
  );

  assign addr_one = s_q.ctrl1[mon_pkg::ADDR1_W-1:0];
  assign addr_two = s_q.ctrl2[mon_pkg::ADDR2_W-1:0];

  // channel setup taken straight from the control registers
  assign ch[0].var_value = s_q.raw[0];
  assign ch[0].var_fresh = s_q.fresh[0];
  assign ch[0].scale     = s_q.ctrl1[mon_pkg::SCALE1_LSB +: mon_pkg::FIELD_W];
  assign ch[0].mult      = s_q.ctrl1[mon_pkg::MULT1_LSB +: mon_pkg::FIELD_W];
  assign ch[0].unipolar  = s_q.ctrl1[mon_pkg::POL1_BIT];
  assign ch[1].var_value = s_q.raw[1];
  assign ch[1].var_fresh = s_q.fresh[1];
  assign ch[1].scale     = s_q.ctrl2[mon_pkg::SCALE2_LSB +: mon_pkg::FIELD_W];
  assign ch[1].mult      = s_q.ctrl2[mon_pkg::MULT2_LSB +: mon_pkg::FIELD_W];
  assign ch[1].unipolar  = s_q.ctrl2[mon_pkg::POL2_BIT];

  genvar g;
  generate
    for (g = 0; g < mon_pkg::NUM_CH; g++) begin : gen_ch
      mon_scaler #(
        .CODE_W (CODE_W)
      ) u_scaler (
        .clk_i  (clk_i),
        .rst_ni (rst_n),
        .ch     (ch[g]),
        .code_o (code[g])
      );
    end
  endgenerate

  always_comb begin
    s_d       = s_q;
    s_d.fresh = '0;

    // register writes; read-only and unmapped words ignore writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        mon_pkg::OUT1_CTRL_OFS: begin
          s_d.ctrl1 = (s_q.ctrl1 & ~mon_pkg::CTRL1_WMASK)
                    | (reg_wdata_i & mon_pkg::CTRL1_WMASK);
        end
        mon_pkg::OUT2_CTRL_OFS: begin
          s_d.ctrl2 = (s_q.ctrl2 & ~mon_pkg::CTRL2_WMASK)
                    | (reg_wdata_i & mon_pkg::CTRL2_WMASK);
        end
        default: begin
          s_d.ctrl1 = s_q.ctrl1;
        end
      endcase
    end

    // read data valid in the cycle after the strobe only
    s_d.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        mon_pkg::CUR_GAIN_OFS: begin
          s_d.rdata[mon_pkg::GAIN_HI_LSB +: mon_pkg::GAIN_W] = cur_integral_gain_i;
          s_d.rdata[mon_pkg::GAIN_W-1:0] = cur_proportional_gain_i;
        end
        mon_pkg::SPD_GAIN_OFS: begin
          s_d.rdata[mon_pkg::GAIN_HI_LSB +: mon_pkg::GAIN_W] = spd_integral_gain_i;
          s_d.rdata[mon_pkg::GAIN_W-1:0] = spd_proportional_gain_i;
        end
        mon_pkg::OUT1_CTRL_OFS: begin
          s_d.rdata = s_q.ctrl1;
        end
        mon_pkg::OUT2_CTRL_OFS: begin
          s_d.rdata = s_q.ctrl2;
        end
        mon_pkg::OUT1_STAT_OFS: begin
          s_d.rdata[mon_pkg::STAT_LSB +: CODE_W] = code[0];
          s_d.rdata[mon_pkg::VAR_W-1:0]         = s_q.raw[0];
        end
        mon_pkg::OUT2_STAT_OFS: begin
          s_d.rdata[mon_pkg::STAT_LSB +: CODE_W] = code[1];
          s_d.rdata[mon_pkg::VAR_W-1:0]         = s_q.raw[1];
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end

    // round-robin fetch; each channel's address is latched from its control register in the cycle before its fetch
    unique case (s_q.fstate)
      mon_pkg::FETCH_ONE: begin
        s_d.fstate = mon_pkg::TAKE_ONE;
      end
      mon_pkg::TAKE_ONE: begin
        s_d.raw[0]   = var_rdata_i;
        s_d.fresh[0] = 1'b1;
        s_d.vaddr    = addr_two;
        s_d.fstate   = mon_pkg::FETCH_TWO;
      end
      mon_pkg::FETCH_TWO: begin
        s_d.fstate = mon_pkg::TAKE_TWO;
      end
      mon_pkg::TAKE_TWO: begin
        s_d.raw[1]   = var_rdata_i;
        s_d.fresh[1] = 1'b1;
        s_d.vaddr    = {{(mon_pkg::VAR_ADDR_W - mon_pkg::ADDR1_W){1'b0}}, addr_one};
        s_d.fstate   = mon_pkg::FETCH_ONE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q        <= '0;
      s_q.ctrl1  <= mon_pkg::CTRL1_RST;
      s_q.ctrl2  <= mon_pkg::CTRL2_RST;
      s_q.fstate <= mon_pkg::FETCH_ONE;
    end else begin
      s_q <= s_d;
    end
  end

  // strobe is combinational from state; address comes from a flop
  assign var_rd_o          = (s_q.fstate == mon_pkg::FETCH_ONE)
                           | (s_q.fstate == mon_pkg::FETCH_TWO);
  assign var_addr_o        = s_q.vaddr;
  assign reg_rdata_o       = s_q.rdata;
  assign monitor_out_one_o = code[0];
  assign monitor_out_two_o = code[1];

endmodule
`default_nettype wire

// ---- bench/dac_variable_monitor_checker.sv ----
// Purpose: port assertions for the monitor block
// Assumes: checks start once the synced reset is surely released
// Notes:   readback, fetch rhythm, channel turns
`timescale 1ns/100ps
`default_nettype none
module dac_variable_monitor_checker #(
  parameter int CODE_W = 12
) (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              resetn_i,
  // register port
  input wire logic [11:0]       reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [31:0]       reg_rdata_o,
  // gains, fetch, codes
  input wire logic [9:0]        cur_integral_gain_i,
  input wire logic [9:0]        cur_proportional_gain_i,
  input wire logic [9:0]        spd_integral_gain_i,
  input wire logic [9:0]        spd_proportional_gain_i,
  input wire logic              var_rd_o,
  input wire logic [CODE_W-1:0] monitor_out_one_o,
  input wire logic [CODE_W-1:0] monitor_out_two_o
);
  logic [2:0] up_q;
  // two-flop release: skip the first edges
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) up_q <= 3'h0;
    else if (!up_q[2]) up_q <= up_q + 3'h1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i || !up_q[2]);
  property p_cur;
    reg_rd_i && reg_addr_i == mon_pkg::CUR_GAIN_OFS |=> reg_rdata_o ==
      {6'h00, $past(cur_integral_gain_i), 6'h00, $past(cur_proportional_gain_i)};
  endproperty
  a_cur: assert property (p_cur) else $error("current gain readback wrong");
  property p_spd;
    reg_rd_i && reg_addr_i == mon_pkg::SPD_GAIN_OFS |=> reg_rdata_o ==
      {6'h00, $past(spd_integral_gain_i), 6'h00, $past(spd_proportional_gain_i)};
  endproperty
  a_spd: assert property (p_spd) else $error("speed gain readback wrong");
  property p_idle;
    !reg_rd_i |=> reg_rdata_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_ctl1;
    reg_wr_i && reg_addr_i == mon_pkg::OUT1_CTRL_OFS ##1
      reg_rd_i && reg_addr_i == mon_pkg::OUT1_CTRL_OFS |=>
      reg_rdata_o == ($past(reg_wdata_i, 2) & mon_pkg::CTRL1_WMASK);
  endproperty
  a_ctl1: assert property (p_ctl1) else $error("ctrl one readback wrong");
  property p_ctl2;
    reg_wr_i && reg_addr_i == mon_pkg::OUT2_CTRL_OFS ##1
      reg_rd_i && reg_addr_i == mon_pkg::OUT2_CTRL_OFS |=>
      reg_rdata_o == ($past(reg_wdata_i, 2) & mon_pkg::CTRL2_WMASK);
  endproperty
  a_ctl2: assert property (p_ctl2) else $error("ctrl two readback wrong");
  property p_fetch_off;
    var_rd_o |=> !var_rd_o;
  endproperty
  a_fetch_off: assert property (p_fetch_off) else $error("fetch strobe held");
  property p_fetch_on;
    !var_rd_o |=> var_rd_o;
  endproperty
  a_fetch_on: assert property (p_fetch_on) else $error("fetch strobe missing");
  property p_turns;
    !$stable(monitor_out_one_o) |-> $stable(monitor_out_two_o);
  endproperty
  a_turns: assert property (p_turns) else $error("both codes moved at once");
  c_ctl1: cover property (reg_wr_i && reg_addr_i == mon_pkg::OUT1_CTRL_OFS);
  c_one: cover property (!$stable(monitor_out_one_o));
  c_two: cover property (!$stable(monitor_out_two_o));
endmodule
bind dac_variable_monitor dac_variable_monitor_checker #(.CODE_W(CODE_W)) checker_inst (
  .clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .cur_integral_gain_i, .cur_proportional_gain_i, .spd_integral_gain_i,
  .spd_proportional_gain_i, .var_rd_o, .monitor_out_one_o, .monitor_out_two_o);
`default_nettype wire

// ---- bench/test_dac_variable_monitor.sv ----
// Purpose: self-checking bench for the monitor block
// Assumes: bench answers each fetch in the cycle after the strobe
// Notes:   random setups, corner values first
`timescale 1ns/100ps
`default_nettype none
module test_dac_variable_monitor;
  localparam int CW = 12;
  logic clk_i, resetn_i, reg_wr_i, reg_rd_i, var_rd_o, fet_q;
  logic [11:0] reg_addr_i, a1;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [9:0] cki, ckp, ski, skp;
  logic [13:0] var_addr_o, adr_q, a2;
  logic [15:0] var_rdata_i, v1, v2;
  logic [CW-1:0] out1, out2, e1, e2;
  logic [63:0] r, q;
  logic [20:0] c1;
  logic [22:0] c2;
  logic [15:0] cv [4] = '{16'h7fff, 16'h8000, 16'h0064, 16'hfffb};
  integer seed = 32'heab0;
  int n_errors, total_checks;
  dac_variable_monitor #(.CODE_W(CW)) dac_variable_monitor_inst (
    .clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .cur_integral_gain_i(cki), .cur_proportional_gain_i(ckp),
    .spd_integral_gain_i(ski), .spd_proportional_gain_i(skp),
    .var_rd_o, .var_addr_o, .var_rdata_i,
    .monitor_out_one_o(out1), .monitor_out_two_o(out2));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [15:0] vfun(logic [13:0] a);
    return a == {2'b00, a1} ? v1 : (a == a2 ? v2 : 16'h5a5a);
  endfunction
  // fetch seen at negedge: no race with the design's own edge
  always @(negedge clk_i) begin
    fet_q = var_rd_o;
    adr_q = var_addr_o;
  end
  // idle bus toggles so a late sample never passes
  always @(posedge clk_i)
    var_rdata_i <= fet_q ? vfun(adr_q) : ~var_rdata_i;
  function automatic logic [CW-1:0] expc(logic [15:0] v, logic [3:0] sc, logic [3:0] mu,
                                         logic up);
    int sv, s, l;
    sv = int'($signed(v));
    s = sc != 4'h0 ? (sv * int'(sc)) >>> 3 : (sv < 0 ? 0 : (sv > 31 ? 31 : sv)) << mu;
    l = up ? s >>> (15 - CW) : (s + 32768) >>> (16 - CW);
    return l < 0 ? '0 : (l > (1 << CW) - 1 ? '1 : CW'(l));
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk(reg_rdata_o, e);
    @(posedge clk_i);
  endtask
  // write then read back at once, no gap
  task automatic wrd(logic [11:0] a, logic [31:0] d, logic [31:0] e);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    rd(a, e);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, fet_q} = 4'h0;
    {reg_addr_i, reg_wdata_i, var_rdata_i, v1, v2, a1, a2} = 118'h0;
    {cki, ckp, ski, skp} = 40'h0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(mon_pkg::OUT1_CTRL_OFS, 32'h00110000);
    rd(mon_pkg::OUT2_CTRL_OFS, mon_pkg::CTRL2_RST);
    rd(12'h0fc, 32'h0);
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    chk({20'h0, out1}, {20'h0, expc(16'h0, 4'h8, 4'h8, 1'b0)});
    for (int i = 0; i < 48; i++) begin
      @(posedge clk_i);
      r = {$random(seed), $random(seed)};
      q = {$random(seed), $random(seed)};
      {cki, ckp, ski, skp} <= r[39:0];
      v1 <= i < 4 ? cv[i % 4] : q[15:0];
      v2 <= q[31:16];
      a1 <= r[51:40];
      a2 <= {1'b1, q[44:32]};
      c1 = {r[55:52], i < 2 ? 4'hf : (i < 4 ? 4'h0 : r[59:56]), r[60], r[51:40]};
      c2 = {q[48:45], q[52:49], q[53], 1'b1, q[44:32]};
      wrd(mon_pkg::OUT1_CTRL_OFS, {r[63:61], q[63:56], c1}, {11'h0, c1});
      wrd(mon_pkg::OUT2_CTRL_OFS, {q[63:55], c2}, {9'h0, c2});
      wrd(mon_pkg::CUR_GAIN_OFS, 32'hffffffff, {6'h0, cki, 6'h0, ckp});
      rd(mon_pkg::SPD_GAIN_OFS, {6'h0, ski, 6'h0, skp});
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      e1 = expc(v1, c1[16:13], c1[20:17], c1[12]);
      e2 = expc(v2, c2[18:15], c2[22:19], c2[14]);
      chk({20'h0, out1}, {20'h0, e1});
      chk({20'h0, out2}, {20'h0, e2});
      // status words: code and the raw value fetched from the chosen address
      @(posedge clk_i);
      rd(mon_pkg::OUT1_STAT_OFS, 32'({e1, v1}));
      rd(mon_pkg::OUT2_STAT_OFS, 32'({e2, v2}));
    end
    @(posedge clk_i);
    end_sim;
  end
endmodule
`default_nettype wire
